// ### src/symbol_rx_regs.svh
// timing and width constants for the symbol receive port
// assumes clk_i runs at 250 MHz and doubles as the reference clock
`ifndef SYMBOL_RX_REGS_SVH
`define SYMBOL_RX_REGS_SVH

`define SYS_CLK_KHZ        250000
`define SYMBOL_RECEIVE_CLOCK_10M_KHZ      2500
`define SYMBOL_RECEIVE_CLOCK_100M_KHZ     25000
`define SYMBOL_RECEIVE_CLOCK_DIV_10M      (`SYS_CLK_KHZ / `SYMBOL_RECEIVE_CLOCK_10M_KHZ)
`define SYMBOL_RECEIVE_CLOCK_DIV_100M     (`SYS_CLK_KHZ / `SYMBOL_RECEIVE_CLOCK_100M_KHZ)
`define SYMBOL_WIDTH       5
`define FLOAT_LINE_COUNT   4
`define MEDIA_FIFO_DEPTH   8
`define DIV_COUNT_WIDTH    7

`endif

// ### src/symbol_rx_pkg.sv
// types shared by the symbol receive port
// assumes symbol_rx_regs.svh is on the include path
`include "symbol_rx_regs.svh"

package symbol_rx_pkg;

  typedef enum logic {
    SRC_REFERENCE,
    SRC_RECOVERED
  } clk_source_e;

  typedef struct packed {
    logic                         carrier;
    logic [`SYMBOL_WIDTH-1:0]     symbol;
  } media_word_s;

  typedef logic [`DIV_COUNT_WIDTH-1:0] div_count_t;

endpackage

// ### src/symbol_receive_port.sv
// symbol-mode receive port: media symbols to partner, own receive clock
// assumes media side runs on media_clk_i, partner samples on our clock
//
// Functional notes
// - collision output undriven and meaningless while symbol mode is used
// - receive clock is 2.5 MHz at 10 Mb/s, 25 MHz at 100 Mb/s
// - at 10 Mb/s receive clock is derived from incoming media stream
// - at 10 Mb/s clock keeps running on last packet's timing
// - at 100 Mb/s clock follows recovered stream while link is valid
// - at 100 Mb/s without link clock comes from reference clock
// - 10 Mb/s source change only after carrier sense, before data valid; code switches on or one cycle before the edge raising carrier sense
// - locking at 10 Mb/s may shift clock phase up to 360 degrees
// - bringing up 100 Mb/s link may shift phase up to 360 degrees
// - at 10 Mb/s the clock realigns once per received packet
// - at 100 Mb/s clock aligns once at link setup, then holds
// - five symbol lines, line 0 least and line 4 most significant
// - every media symbol forwarded continuously, no frame gating
// - receive data valid never asserted in symbol mode
// - symbol lines change on rising edges of receive clock
// - drive of symbol lines 0 to 3 gated by float request
// - partner raises float request when floating; only one driver
// - fifth symbol bit leaves on the nibble-mode receive error pin
`timescale 1ns/1ps

module async_symbol_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = `MEDIA_FIFO_DEPTH
) (
  // write side
  input  wire logic             wr_clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  // read side
  input  wire logic             rd_clk_i,
  output logic [WIDTH-1:0]      rd_data_o,
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_bin;
  logic [AW:0]      wr_gray;
  logic [AW:0]      rd_bin;
  logic [AW:0]      rd_gray;
  logic [AW:0]      rd_gray_meta;
  logic [AW:0]      rd_gray_sync;
  logic [AW:0]      wr_gray_meta;
  logic [AW:0]      wr_gray_sync;
  logic [AW:0]      next_wr_bin;
  logic [AW:0]      next_wr_gray;
  logic [AW:0]      next_rd_bin;
  logic             wr_fire;
  logic             rd_fire;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  assign wr_fire      = wr_valid_i && wr_ready_o;
  assign next_wr_bin  = wr_bin + {{AW{1'b0}}, wr_fire};
  assign next_wr_gray = to_gray(next_wr_bin);
  assign rd_valid_o   = (rd_gray != wr_gray_sync);
  assign rd_fire      = rd_valid_o && rd_ready_i;
  assign next_rd_bin  = rd_bin + {{AW{1'b0}}, rd_fire};
  assign rd_data_o    = mem[rd_bin[AW-1:0]];

  always_ff @(posedge wr_clk_i) begin
    if (wr_fire) begin
      mem[wr_bin[AW-1:0]] <= wr_data_i;
    end
  end

  // write pointer and registered room indication
  always_ff @(posedge wr_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_bin     <= '0;
      wr_gray    <= '0;
      wr_ready_o <= 1'b0;
    end else begin
      wr_bin     <= next_wr_bin;
      wr_gray    <= next_wr_gray;
      wr_ready_o <= (next_wr_gray !=
                     {~rd_gray_sync[AW:AW-1], rd_gray_sync[AW-2:0]});
    end
  end

  always_ff @(posedge wr_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_gray_meta <= '0;
      rd_gray_sync <= '0;
    end else begin
      rd_gray_meta <= rd_gray;
      rd_gray_sync <= rd_gray_meta;
    end
  end

  always_ff @(posedge rd_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_bin  <= '0;
      rd_gray <= '0;
    end else begin
      rd_bin  <= next_rd_bin;
      rd_gray <= to_gray(next_rd_bin);
    end
  end

  always_ff @(posedge rd_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_gray_meta <= '0;
      wr_gray_sync <= '0;
    end else begin
      wr_gray_meta <= wr_gray;
      wr_gray_sync <= wr_gray_meta;
    end
  end
endmodule // async_symbol_fifo

module symbol_receive_port
  import symbol_rx_pkg::*;
#(
  parameter int FIFO_DEPTH = `MEDIA_FIFO_DEPTH,
  parameter int DIV_10M    = `SYMBOL_RECEIVE_CLOCK_DIV_10M,
  parameter int DIV_100M   = `SYMBOL_RECEIVE_CLOCK_DIV_100M
) (
  // system clock, also the reference clock
  input  wire logic                          clk_i,
  input  wire logic                          reset_n_i,
  // media side, recovered line clock domain
  input  wire logic                          media_clk_i,
  input  wire logic [`SYMBOL_WIDTH-1:0]      media_symbol_i,
  input  wire logic                          media_carrier_i,
  input  wire logic                          media_valid_i,
  output logic                               media_ready_o,
  // line status pins
  input  wire logic                          link_up_i,
  input  wire logic                          speed_100_i,
  // partner side
  output logic                               symbol_receive_clock_o,
  output logic [`SYMBOL_WIDTH-1:0]           symbol_receive_lines_o,
  output logic [`FLOAT_LINE_COUNT-1:0]       symbol_lines_oe_n_o,
  output logic                               symbol_carrier_sense_o,
  output logic                               rx_data_valid_o,
  output logic                               collision_o,
  output logic                               collision_oe_n_o,
  input  wire logic                          receive_float_request_i
);
  media_word_s  media_word;
  media_word_s  head_word;
  logic         head_valid;
  logic         pop;
  logic [1:0]   link_meta;
  logic [1:0]   speed_meta;
  logic [1:0]   float_meta;
  logic         link_sync;
  logic         speed_sync;
  logic         float_sync;
  logic         link_aligned;
  logic         carrier_q;
  clk_source_e  clk_source;
  div_count_t   div_cnt;
  div_count_t   div_len;
  div_count_t   next_div_cnt;
  logic         realign;
  logic         tick;

  assign media_word.carrier = media_carrier_i;
  assign media_word.symbol  = media_symbol_i;

  async_symbol_fifo #(
    .WIDTH ($bits(media_word_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_media_fifo (
    .wr_clk_i   (media_clk_i),
    .reset_n_i  (reset_n_i),
    .wr_data_i  (media_word),
    .wr_valid_i (media_valid_i),
    .wr_ready_o (media_ready_o),
    .rd_clk_i   (clk_i),
    .rd_data_o  (head_word),
    .rd_valid_o (head_valid),
    .rd_ready_i (pop)
  );

  // pin synchronisers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link_meta  <= 2'h0;
      speed_meta <= 2'h0;
      float_meta <= 2'h3;
    end else begin
      link_meta  <= {link_meta[0], link_up_i};
      speed_meta <= {speed_meta[0], speed_100_i};
      float_meta <= {float_meta[0], receive_float_request_i};
    end
  end

  assign link_sync  = link_meta[1];
  assign speed_sync = speed_meta[1];
  assign float_sync = float_meta[1];

  assign div_len = speed_sync ? div_count_t'(DIV_100M)
                              : div_count_t'(DIV_10M);

  // realign at packet start; before data valid could rise
  // 100 Mb/s aligns only on link establishment
  assign realign = speed_sync
                 ? (link_sync && !link_aligned)
                 : (head_valid && head_word.carrier && !carrier_q);

  // restart may cut the current period short
  // a realign parks the count on the last low cycle, so the phase jump
  // still ends in a clean rising edge, on which the new lines are shown
  assign tick         = (div_cnt >= div_len - div_count_t'(1));
  assign next_div_cnt = tick    ? '0 :
                        realign ? div_len - div_count_t'(1) :
                                  div_cnt + div_count_t'(1);
  // one symbol per receive clock rise, no frame gating
  assign pop          = tick && head_valid;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      link_aligned <= 1'b0;
    end else begin
      link_aligned <= speed_sync && link_sync && (link_aligned || realign);
    end
  end

  // clock source selection
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clk_source <= SRC_REFERENCE;
    end else if (speed_sync) begin
      clk_source <= link_sync ? SRC_RECOVERED : SRC_REFERENCE;
    end else if (realign) begin
      // lock to stream, keep timing after it ends
      clk_source <= SRC_RECOVERED;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt                <= '0;
      symbol_receive_clock_o <= 1'b0;
    end else begin
      div_cnt                <= next_div_cnt;
      // high for first half of each period
      symbol_receive_clock_o <= (next_div_cnt < (div_len >> 1));
    end
  end

  // symbol and carrier lines
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      symbol_receive_lines_o <= '0;
      symbol_carrier_sense_o <= 1'b0;
      carrier_q              <= 1'b0;
    end else if (pop) begin
      // update with the rising clock, bit 4 on error pin
      symbol_receive_lines_o <= head_word.symbol;
      symbol_carrier_sense_o <= head_word.carrier;
      carrier_q              <= head_word.carrier;
    end
  end

  // fixed pins and float control
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      symbol_lines_oe_n_o <= '1;
      rx_data_valid_o     <= 1'b0;
      collision_o         <= 1'b0;
      collision_oe_n_o    <= 1'b1;
    end else begin
      // release lines 0..3 while partner floats
      symbol_lines_oe_n_o <= {`FLOAT_LINE_COUNT{float_sync}};
      rx_data_valid_o     <= 1'b0;
      collision_o         <= 1'b0;
      collision_oe_n_o    <= 1'b1;
    end
  end
endmodule // symbol_receive_port

// ### tb/symbol_port_props.sv
// assertions on the symbol receive port's partner-side pins
// assumes a bind from the bench and the divider values of the port
`timescale 1ns/1ps
module symbol_port_props #(
  parameter int DIV_10M  = 100,
  parameter int DIV_100M = 10
) (
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic       link_up_i,
  input wire logic       speed_100_i,
  input wire logic       symbol_receive_clock_o,
  input wire logic [4:0] symbol_receive_lines_o,
  input wire logic [3:0] symbol_lines_oe_n_o,
  input wire logic       symbol_carrier_sense_o,
  input wire logic       rx_data_valid_o,
  input wire logic       collision_oe_n_o,
  input wire logic       receive_float_request_i
);
  // a realign may cut one period short; the bound allows up to two periods
  localparam int P10 = 2 * DIV_10M;
  // cycles since reset, saturating; pin synchronisers settle first
  logic [3:0] settle;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      settle <= 4'h0;
    end else if (settle != 4'hF) begin
      settle <= settle + 4'h1;
    end
  end
  a_valid_held_low: assert property (!rx_data_valid_o)
    else $error("data valid raised");
  a_collision_not_driven: assert property (collision_oe_n_o)
    else $error("collision pin driven");
  a_float_lines_off: assert property (
    receive_float_request_i [*6] |-> symbol_lines_oe_n_o == 4'hF)
    else $error("lines driven while floating");
  a_float_lines_on: assert property (
    !receive_float_request_i [*6] |-> symbol_lines_oe_n_o == 4'h0)
    else $error("lines not driven");
  a_lines_on_rise: assert property (
    $changed(symbol_receive_lines_o) |-> $rose(symbol_receive_clock_o))
    else $error("lines changed off the rising edge");
  a_carrier_on_rise: assert property (
    $changed(symbol_carrier_sense_o) |-> $rose(symbol_receive_clock_o))
    else $error("carrier changed off the rising edge");
  a_fast_period_exact: assert property (
    $rose(symbol_receive_clock_o) && speed_100_i && settle == 4'hF
    && link_up_i == $past(link_up_i, 8) |-> ##DIV_100M
    ($rose(symbol_receive_clock_o) || link_up_i != $past(link_up_i, 8)))
    else $error("fast receive clock period wrong");
  a_slow_clock_runs: assert property (
    $rose(symbol_receive_clock_o) && !speed_100_i
    |-> ##[1:P10] $rose(symbol_receive_clock_o))
    else $error("slow receive clock stopped");
endmodule // symbol_port_props

// ### tb/symbol_sink_model.sv
// stand-in for the MAC that samples the symbol lines
// assumes the port's partner-side pins are wired to it
`timescale 1ns/1ps
module symbol_sink_model (
  input  wire logic       rx_clk_i,
  input  wire logic [4:0] lines_i,
  input  wire logic [3:0] oe_n_i,
  input  wire logic       float_cmd_i,
  output logic            float_o
);
  logic [4:0] seen[$];
  logic [4:0] last = 5'h00;
  assign float_o = float_cmd_i;
  // sample mid-period on the port's own clock, skip while floating
  always @(negedge rx_clk_i)
    if (oe_n_i == 4'h0 && lines_i !== last) begin
      seen.push_back(lines_i);
      last = lines_i;
    end
endmodule // symbol_sink_model

// ### tb/testbench.sv
// self-checking bench for the symbol receive port
// assumes the package, checker and sink model compile first
`timescale 1ns/1ps
module testbench;
  import symbol_rx_pkg::*;
  localparam int D10  = 64;
  localparam int D100 = 4;
  logic        clk_i = 0, media_clk_i = 0, reset_n_i = 0;
  logic [4:0]  media_symbol_i = '0, lines;
  logic        media_carrier_i = 0, media_valid_i = 0, media_ready_o;
  logic        link_up_i = 0, speed_100_i = 1, float_cmd = 0, float_req;
  logic        sclk, carrier, valid, coll, coll_oe_n;
  logic [3:0]  oe_n;
  int          failures = 0, total_checks = 0, stalls = 0;
  media_word_s sent[$];
  always #2 clk_i = ~clk_i;
  initial begin
    #7;
    forever #24 media_clk_i = ~media_clk_i;
  end
  symbol_receive_port #(.DIV_10M(D10), .DIV_100M(D100)) dut (
    .clk_i, .reset_n_i, .media_clk_i, .media_symbol_i, .media_carrier_i,
    .media_valid_i, .media_ready_o, .link_up_i, .speed_100_i,
    .symbol_receive_clock_o(sclk), .symbol_receive_lines_o(lines),
    .symbol_lines_oe_n_o(oe_n), .symbol_carrier_sense_o(carrier),
    .rx_data_valid_o(valid), .collision_o(coll),
    .collision_oe_n_o(coll_oe_n), .receive_float_request_i(float_req));
  symbol_sink_model sink (.rx_clk_i(sclk), .lines_i(lines), .oe_n_i(oe_n),
    .float_cmd_i(float_cmd), .float_o(float_req));
  task automatic check(input string n, input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic do_reset(input logic fast, input int n);
    @(negedge clk_i);
    reset_n_i = 0;
    speed_100_i = fast;
    repeat (n) @(negedge clk_i);
    reset_n_i = 1;
    repeat (2) @(posedge sclk);
  endtask
  task automatic send(input media_word_s w);
    @(negedge media_clk_i);
    {media_carrier_i, media_symbol_i} = w;
    media_valid_i = 1;
    @(posedge media_clk_i);
    while (media_ready_o !== 1'b1) begin
      stalls++;
      @(posedge media_clk_i);
    end
  endtask
  task automatic stream(input logic c, input int n, input logic [4:0] x);
    sent.delete();
    sink.seen.delete();
    for (int i = 1; i <= n; i++) begin
      sent.push_back('{carrier: c, symbol: 5'(i) ^ x});
      send(sent[$]);
    end
    @(negedge media_clk_i) media_valid_i = 0;
  endtask
  task automatic expect_seen(input string n);
    repeat (sent.size() + 4) @(posedge sclk);
    @(negedge clk_i);
    check(n, 8'(sent.size()), 8'(sink.seen.size()));
    foreach (sent[i]) check(n, 8'(sent[i].symbol), 8'(sink.seen[i]));
  endtask
  task automatic period(input string n, input logic [7:0] e);
    time t;
    @(posedge sclk);
    t = $time;
    @(posedge sclk);
    check(n, e, 8'(($time - t) / 4));
  endtask
  task automatic t_ref_clock();
    period("period no link", 8'(D100));
    stream(0, 31, 5'h00);
    expect_seen("fast lines");
    check("data valid", 8'h0, 8'(valid));
    check("collision oe_n", 8'h1, 8'(coll_oe_n));
    check("collision", 8'h0, 8'(coll));
  endtask
  task automatic t_float();
    @(negedge clk_i) float_cmd = 1;
    repeat (8) @(negedge clk_i);
    check("oe_n floating", 8'hF, 8'(oe_n));
    float_cmd = 0;
    repeat (8) @(negedge clk_i);
    check("oe_n driving", 8'h0, 8'(oe_n));
  endtask
  task automatic t_link_up();
    @(negedge clk_i) link_up_i = 1;
    repeat (12) @(negedge clk_i);
    period("period with link", 8'(D100));
    stream(0, 16, 5'h10);
    expect_seen("lines with link");
  endtask
  task automatic t_packet_slow();
    stalls = 0;
    stream(1, 20, 5'h15);
    check("buffer refused", 8'h1, 8'(stalls > 0));
    expect_seen("slow lines");
    check("carrier sense", 8'h1, 8'(carrier));
    period("slow period", 8'(D10));
  endtask
  initial begin
    do_reset(1, 20);
    t_ref_clock();
    t_float();
    t_link_up();
    do_reset(0, 30);
    t_packet_slow();
    tally_and_finish();
  end
  initial begin
    #100us;
    failures++;
    tally_and_finish();
  end
endmodule // testbench
bind symbol_receive_port symbol_port_props
  #(.DIV_10M(DIV_10M), .DIV_100M(DIV_100M)) props (.*);
